/* rtl/rcsir_top.v */
// Clock setting and interrupt timer registers sharing bus location 15,
// plus the interrupt select / start-stop latches and interrupt flag.
// Assumes bus pins are asynchronous; rollover events and the 10 Hz setting
// pulse come as one-cycle pulses from the timekeeping logic on clk.
`timescale 1ns/1ps
`default_nettype none
`include "rcsir_defs.vh"

module rcsir_top (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Processor bus strobes and address
    input  wire       chipSelN,
    input  wire       readStrobeN,
    input  wire       writeStrobeN,
    input  wire [3:0] addrPin,
    // Processor data pins
    input  wire       dataBitZeroIn,
    output wire       dataBitZeroOut,
    output wire       dataBitZeroOe,
    input  wire       dataBitOneIn,
    output wire       dataBitOneOut,
    output wire       dataBitOneOe,
    input  wire       dataBitTwoIn,
    output wire       dataBitTwoOut,
    output wire       dataBitTwoOe,
    input  wire       dataBitThreeIn,
    output wire       dataBitThreeOut,
    output wire       dataBitThreeOe,
    // Open-drain interrupt pin
    output wire       irqPinOut,
    output wire       irqPinOe,
    // Timekeeping events
    input  wire       settingPulse,
    input  wire       pmRollover,
    input  wire       yearRollover,
    // State for the calendar logic
    output wire       pmIndicator,
    output wire       hourModeBit,
    output wire [1:0] leapCount,
    output wire       febDay29Allowed,
    output wire       intSelect
);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    wire [10:0] pinSync;
    wire        csSN;
    wire        rdSN;
    wire        wrSN;
    wire [3:0]  addrS;
    wire [3:0]  dataS;

    rcsir_sync #(
        .WIDTH (11)
    ) uPinSync (
        .clk     (clk),
        .rst     (rst),
        .pinIn   ({chipSelN, readStrobeN, writeStrobeN, addrPin,
                   dataBitThreeIn, dataBitTwoIn, dataBitOneIn,
                   dataBitZeroIn}),
        .syncOut (pinSync)
    );

    assign csSN  = pinSync[10];
    assign rdSN  = pinSync[9];
    assign wrSN  = pinSync[8];
    assign addrS = pinSync[7:4];
    assign dataS = pinSync[3:0];

    // ------------------------------------------------------------------
    // Strobe edges
    // ------------------------------------------------------------------
    wire       rdActive = ~csSN & ~rdSN;
    wire       wrActive = ~csSN & ~wrSN;
    reg        rdActive_ff;
    reg        wrActive_ff;
    reg  [3:0] rdAddr_ff;
    reg  [3:0] wrAddr_ff;
    reg  [3:0] wrData_ff;

    wire rdStart = rdActive & ~rdActive_ff;
    wire rdEnd   = rdActive_ff & ~rdActive;
    wire wrEnd   = wrActive_ff & ~wrActive;

    always @(posedge clk) begin
        if (rst) begin
            rdActive_ff <= 1'b0;
            wrActive_ff <= 1'b0;
            rdAddr_ff   <= 4'h0;
            wrAddr_ff   <= 4'h0;
            wrData_ff   <= 4'h0;
        end else begin
            rdActive_ff <= rdActive;
            wrActive_ff <= wrActive;
            if (rdStart) begin
                rdAddr_ff <= addrS;
            end
            // Address and data are taken while the strobe is low and
            // committed at its trailing edge
            if (wrActive) begin
                wrAddr_ff <= addrS;
                wrData_ff <= dataS;
            end
        end
    end

    wire ctrlReading = rdActive_ff & (rdAddr_ff == `RCSIR_ADDR_CTRL);
    wire ctrlReadEnd = rdEnd & (rdAddr_ff == `RCSIR_ADDR_CTRL);
    wire ctrlWrite   = wrEnd & (wrAddr_ff == `RCSIR_ADDR_CTRL);
    wire sharedWrite = wrEnd & (wrAddr_ff == `RCSIR_ADDR_SHARED);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg        intSelect_ff;
    reg        intStop_ff;
    reg        hourMode_ff;
    reg        pm_ff;
    reg  [1:0] leap_ff;
    reg  [2:0] intDelay_ff;
    reg        intRepeat_ff;
    reg        intFlag_ff;
    reg        intPending_ff;
    wire       timeout;
    wire [3:0] csrRstVal = `RCSIR_RST_CSR;
    wire [3:0] itrRstVal = `RCSIR_RST_ITR;

    wire csrWrite   = sharedWrite & ~intSelect_ff;
    wire itrWrite   = sharedWrite & intSelect_ff;
    wire noDelayWr  = itrWrite &
        (wrData_ff[`RCSIR_ITR_DELAY_HI:`RCSIR_ITR_DELAY_LO]
         == `RCSIR_DELAY_NONE);

    // Control latches
    always @(posedge clk) begin
        if (rst) begin
            intSelect_ff <= `RCSIR_RST_INT_SELECT;
        end else if (ctrlWrite) begin
            intSelect_ff <= wrData_ff[`RCSIR_CTRL_INT_SELECT];
        end
    end

    // Interrupt start/stop; hardware forcing to stop wins over a write
    always @(posedge clk) begin
        if (rst) begin
            intStop_ff <= `RCSIR_RST_INT_STOP;
        end else if (noDelayWr) begin
            intStop_ff <= 1'b1;
        end else if (timeout && !intRepeat_ff) begin
            intStop_ff <= 1'b1;
        end else if (ctrlWrite) begin
            intStop_ff <= wrData_ff[`RCSIR_CTRL_INT_STOP];
        end
    end

    // Clock setting register
    always @(posedge clk) begin
        if (rst) begin
            hourMode_ff <= csrRstVal[`RCSIR_CSR_HOUR_MODE];
            pm_ff       <= csrRstVal[`RCSIR_CSR_PM];
            leap_ff     <= csrRstVal[`RCSIR_CSR_LEAP_HI:`RCSIR_CSR_LEAP_LO];
        end else begin
            if (csrWrite) begin
                hourMode_ff <= wrData_ff[`RCSIR_CSR_HOUR_MODE];
                pm_ff       <= wrData_ff[`RCSIR_CSR_PM];
            end else if (pmRollover) begin
                pm_ff <= ~pm_ff;
            end
            if (csrWrite) begin
                leap_ff <= wrData_ff[`RCSIR_CSR_LEAP_HI:`RCSIR_CSR_LEAP_LO];
            end else if (yearRollover) begin
                leap_ff <= leap_ff + 2'h1;
            end
        end
    end

    // Interrupt timer register
    always @(posedge clk) begin
        if (rst) begin
            intDelay_ff  <=
                itrRstVal[`RCSIR_ITR_DELAY_HI:`RCSIR_ITR_DELAY_LO];
            intRepeat_ff <= itrRstVal[`RCSIR_ITR_REPEAT];
        end else if (itrWrite) begin
            intDelay_ff  <=
                wrData_ff[`RCSIR_ITR_DELAY_HI:`RCSIR_ITR_DELAY_LO];
            intRepeat_ff <= wrData_ff[`RCSIR_ITR_REPEAT];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt timer and flag
    // ------------------------------------------------------------------
    wire timerRun = ~intStop_ff & (intDelay_ff != `RCSIR_DELAY_NONE);

    // Timer runs regardless of which register sits at location 15
    rcsir_int_timer #(
        .CNT_W (10)
    ) uIntTimer (
        .clk          (clk),
        .rst          (rst),
        .run          (timerRun),
        .tickPulse    (settingPulse),
        .delayCode    (intDelay_ff),
        .timeoutPulse (timeout)
    );

    // A timeout during a control read, from its second cycle on, is held back until the read ends
    always @(posedge clk) begin
        if (rst) begin
            intFlag_ff    <= 1'b0;
            intPending_ff <= 1'b0;
        end else if (noDelayWr) begin
            intFlag_ff    <= 1'b0;
            intPending_ff <= 1'b0;
        end else if (ctrlReadEnd) begin
            intFlag_ff    <= intPending_ff | timeout;
            intPending_ff <= 1'b0;
        end else if (timeout) begin
            if (ctrlReading) begin
                intPending_ff <= 1'b1;
            end else begin
                intFlag_ff <= 1'b1;
            end
        end
    end

    assign irqPinOut = 1'b0;
    assign irqPinOe  = intFlag_ff;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    reg  [3:0] readData_ff;
    reg  [3:0] nxt_readData;
    reg        readHit_ff;

    always @* begin
        nxt_readData = 4'h0;
        if (addrS == `RCSIR_ADDR_CTRL) begin
            nxt_readData[`RCSIR_STAT_INT_FLAG] = intFlag_ff;
        end else if (addrS == `RCSIR_ADDR_SHARED && intSelect_ff) begin
            nxt_readData = {intRepeat_ff, intDelay_ff};
        end else if (addrS == `RCSIR_ADDR_SHARED) begin
            nxt_readData = {leap_ff, pm_ff, hourMode_ff};
        end
    end

    // Data latched at the start of a read stays stable throughout it
    always @(posedge clk) begin
        if (rst) begin
            readData_ff <= 4'h0;
            readHit_ff  <= 1'b0;
        end else if (rdStart) begin
            readData_ff <= nxt_readData;
            readHit_ff  <= (addrS == `RCSIR_ADDR_CTRL) ||
                           (addrS == `RCSIR_ADDR_SHARED);
        end
    end

    wire driveBus = rdActive & rdActive_ff & readHit_ff;

    assign dataBitZeroOut  = readData_ff[0];
    assign dataBitOneOut   = readData_ff[1];
    assign dataBitTwoOut   = readData_ff[2];
    assign dataBitThreeOut = readData_ff[3];
    assign dataBitZeroOe   = driveBus;
    assign dataBitOneOe    = driveBus;
    assign dataBitTwoOe    = driveBus;
    assign dataBitThreeOe  = driveBus;

    // ------------------------------------------------------------------
    // State to the calendar logic
    // ------------------------------------------------------------------
    assign pmIndicator     = pm_ff;
    assign hourModeBit     = hourMode_ff;
    assign leapCount       = leap_ff;
    assign febDay29Allowed = (leap_ff == 2'h0);
    assign intSelect       = intSelect_ff;

endmodule

`default_nettype wire

/* pkg/rcsir_defs.vh */
// Constants for the address-15 clock setting / interrupt register block.
// Assumes a 200 MHz system clock and a 10 Hz setting pulse from the divider.
`ifndef RCSIR_DEFS_VH
`define RCSIR_DEFS_VH

// ----------------------------------------------------------------------
// Register locations on the 4-bit bus
// ----------------------------------------------------------------------
`define RCSIR_ADDR_CTRL        4'h0
`define RCSIR_ADDR_SHARED      4'hF

// ----------------------------------------------------------------------
// Control register write bits
// ----------------------------------------------------------------------
`define RCSIR_CTRL_INT_STOP    0
`define RCSIR_CTRL_INT_SELECT  1
// Control register read bits
`define RCSIR_STAT_INT_FLAG    0

// ----------------------------------------------------------------------
// Clock setting register fields
// ----------------------------------------------------------------------
`define RCSIR_CSR_HOUR_MODE    0
`define RCSIR_CSR_PM           1
`define RCSIR_CSR_LEAP_LO      2
`define RCSIR_CSR_LEAP_HI      3

// ----------------------------------------------------------------------
// Interrupt timer register fields
// ----------------------------------------------------------------------
`define RCSIR_ITR_DELAY_HI     2
`define RCSIR_ITR_DELAY_LO     0
`define RCSIR_ITR_REPEAT       3
`define RCSIR_DELAY_NONE       3'h0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RCSIR_RST_CSR          4'h0
`define RCSIR_RST_ITR          4'h0
`define RCSIR_RST_INT_STOP     1'b1
`define RCSIR_RST_INT_SELECT   1'b0

// ----------------------------------------------------------------------
// Timeout periods in tenths of a second (setting pulses)
// ----------------------------------------------------------------------
`define RCSIR_TICKS_CODE1      10'h001
`define RCSIR_TICKS_CODE2      10'h005
`define RCSIR_TICKS_CODE3      10'h00A
`define RCSIR_TICKS_CODE4      10'h032
`define RCSIR_TICKS_CODE5      10'h064
`define RCSIR_TICKS_CODE6      10'h12C
`define RCSIR_TICKS_CODE7      10'h258

`endif

/* rtl/rcsir_sync.v */
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are quasi-static levels from outside the clk domain.
`timescale 1ns/1ps
`default_nettype none

module rcsir_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    // Pin levels in, synchronised levels out
    input  wire [WIDTH-1:0] pinIn,
    output wire [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] stage1_ff;
    reg [WIDTH-1:0] stage2_ff;

    always @(posedge clk) begin
        if (rst) begin
            stage1_ff <= {WIDTH{1'b1}};
            stage2_ff <= {WIDTH{1'b1}};
        end else begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;

endmodule

`default_nettype wire

/* rtl/rcsir_int_timer.v */
// Interrupt delay timer counting 10 Hz setting pulses.
// Assumes tickPulse is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "rcsir_defs.vh"

module rcsir_int_timer #(
    parameter CNT_W = 10
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Control
    input  wire       run,
    input  wire       tickPulse,
    input  wire [2:0] delayCode,
    // Event
    output reg        timeoutPulse
);

    reg  [CNT_W-1:0] count_ff;
    reg  [CNT_W-1:0] terminal;

    always @* begin
        case (delayCode)
            3'h1: terminal = `RCSIR_TICKS_CODE1;
            3'h2: terminal = `RCSIR_TICKS_CODE2;
            3'h3: terminal = `RCSIR_TICKS_CODE3;
            3'h4: terminal = `RCSIR_TICKS_CODE4;
            3'h5: terminal = `RCSIR_TICKS_CODE5;
            3'h6: terminal = `RCSIR_TICKS_CODE6;
            3'h7: terminal = `RCSIR_TICKS_CODE7;
            default: terminal = {CNT_W{1'b1}};
        endcase
    end

    // Restart from zero on the timeout itself keeps later ones aligned
    always @(posedge clk) begin
        if (rst || !run) begin
            count_ff     <= {CNT_W{1'b0}};
            timeoutPulse <= 1'b0;
        end else if (tickPulse) begin
            if (count_ff + 1'b1 >= terminal) begin
                count_ff     <= {CNT_W{1'b0}};
                timeoutPulse <= 1'b1;
            end else begin
                count_ff     <= count_ff + 1'b1;
                timeoutPulse <= 1'b0;
            end
        end else begin
            timeoutPulse <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* tb/rcsir_monitor.sv */
// Checker for the shared location-15 register block.
// Assumes it is bound to rcsir_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module rcsir_monitor (
    // Clock and reset
    input wire       clk,
    input wire       rst,
    // Bus strobes
    input wire       chipSelN,
    input wire       readStrobeN,
    input wire       writeStrobeN,
    // Drive enables and interrupt pin level
    input wire       dataBitZeroOe,
    input wire       dataBitOneOe,
    input wire       dataBitTwoOe,
    input wire       dataBitThreeOe,
    input wire       irqPinOut,
    input wire       irqPinOe,
    // Events and state
    input wire       settingPulse,
    input wire       pmRollover,
    input wire       yearRollover,
    input wire       pmIndicator,
    input wire       hourModeBit,
    input wire [1:0] leapCount,
    input wire       febDay29Allowed,
    input wire       intSelect
);
    // ------------------------------------------------------------------
    // Quiet-time counters, saturating at 8
    // ------------------------------------------------------------------
    reg [3:0] wrIdle_ff;
    reg [3:0] rdIdle_ff;
    reg [3:0] spIdle_ff;
    always @(posedge clk) begin
        if (rst) begin
            wrIdle_ff <= 4'h0;
            rdIdle_ff <= 4'h0;
            spIdle_ff <= 4'h0;
        end else begin
            wrIdle_ff <= writeStrobeN ?
                wrIdle_ff + {3'h0, wrIdle_ff != 4'h8} : 4'h0;
            rdIdle_ff <= readStrobeN ?
                rdIdle_ff + {3'h0, rdIdle_ff != 4'h8} : 4'h0;
            spIdle_ff <= settingPulse ? 4'h0 :
                spIdle_ff + {3'h0, spIdle_ff != 4'h8};
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_FEB29: assert property (febDay29Allowed == (leapCount == 2'h0))
        else $error("day 29 enable does not follow leap count");
    AST_LEAP_STEP: assert property (yearRollover && wrIdle_ff == 4'h8
        |=> leapCount == $past(leapCount) + 2'h1) else $error("leap step");
    AST_LEAP_HOLD: assert property (!yearRollover && wrIdle_ff == 4'h8
        |=> $stable(leapCount)) else $error("leap count moved");
    AST_PM_TOGGLE: assert property (pmRollover && wrIdle_ff == 4'h8
        |=> pmIndicator != $past(pmIndicator)) else $error("pm not toggled");
    AST_PM_HOLD: assert property (!pmRollover && wrIdle_ff == 4'h8
        |=> $stable(pmIndicator)) else $error("pm moved");
    AST_MODE_WR: assert property (!$stable(hourModeBit)
        |-> wrIdle_ff < 4'h8) else $error("hour mode moved without write");
    AST_SEL_WR: assert property (!$stable(intSelect)
        |-> wrIdle_ff < 4'h8) else $error("select moved without write");
    AST_OE_EQ: assert property ((dataBitZeroOe || dataBitOneOe
        || dataBitTwoOe || dataBitThreeOe) |-> dataBitZeroOe && dataBitOneOe
        && dataBitTwoOe && dataBitThreeOe && !$past(readStrobeN, 2)
        && !$past(chipSelN, 2)) else $error("data enable without read");
    AST_OE_READ: assert property ($rose(dataBitZeroOe) |-> !readStrobeN
        && !chipSelN && !$past(readStrobeN, 2))
        else $error("drive without read");
    AST_IRQ_ODRAIN: assert property (irqPinOut == 1'b0)
        else $error("interrupt pin driven high");
    AST_IRQ_CLR: assert property ($fell(irqPinOe)
        |-> rdIdle_ff < 4'h8 || wrIdle_ff < 4'h8) else $error("irq dropped");
    AST_IRQ_SET: assert property ($rose(irqPinOe)
        |-> spIdle_ff < 4'h4 || rdIdle_ff < 4'h8)
        else $error("irq without tick");
    cover property ($rose(irqPinOe));
    cover property (yearRollover && leapCount == 2'h3);
    cover property ($rose(dataBitZeroOe) && intSelect);
endmodule

bind rcsir_top rcsir_monitor u_rcsir_monitor (.clk(clk), .rst(rst),
    .chipSelN(chipSelN), .readStrobeN(readStrobeN),
    .writeStrobeN(writeStrobeN), .dataBitZeroOe(dataBitZeroOe),
    .dataBitOneOe(dataBitOneOe), .dataBitTwoOe(dataBitTwoOe),
    .dataBitThreeOe(dataBitThreeOe), .irqPinOut(irqPinOut),
    .irqPinOe(irqPinOe), .settingPulse(settingPulse),
    .pmRollover(pmRollover), .yearRollover(yearRollover),
    .pmIndicator(pmIndicator), .hourModeBit(hourModeBit),
    .leapCount(leapCount), .febDay29Allowed(febDay29Allowed),
    .intSelect(intSelect));
`default_nettype wire

/* tb/rcsir_cpu_model.sv */
// Processor on the 4-bit bus: strobed reads and writes.
// Assumes the device drives data only while its enables are high.
`timescale 1ns/1ps
`default_nettype none

module rcsir_cpu_model (
    // Clock
    input  wire        clk,
    // Bus strobes and address
    output logic       chipSelN,
    output logic       readStrobeN,
    output logic       writeStrobeN,
    output logic [3:0] addrPin,
    // Data pins
    input  wire  [3:0] devOut,
    input  wire  [3:0] devOe,
    output wire  [3:0] dataWire
);
    logic       drive;
    logic [3:0] driveData;
    logic [3:0] flip;
    // Undriven bits change every cycle so a stale level never passes
    assign dataWire = (devOe & devOut) | (~devOe & (drive ? driveData : flip));
    always @(posedge clk) flip <= ~dataWire;
    initial begin
        chipSelN = 1'b1;
        readStrobeN = 1'b1;
        writeStrobeN = 1'b1;
        addrPin = 4'h0;
        drive = 1'b0;
        driveData = 4'h0;
        flip = 4'h5;
    end
    task automatic busWrite(input logic [3:0] a, input logic [3:0] d);
        @(negedge clk);
        addrPin = a;
        driveData = d;
        drive = 1'b1;
        chipSelN = 1'b0;
        writeStrobeN = 1'b0;
        repeat (6) @(negedge clk);
        writeStrobeN = 1'b1;
        chipSelN = 1'b1;
        drive = 1'b0;
        repeat (6) @(negedge clk);
    endtask
    task automatic busRead(input logic [3:0] a, output logic [3:0] d,
                           output logic [3:0] oe);
        @(negedge clk);
        addrPin = a;
        chipSelN = 1'b0;
        readStrobeN = 1'b0;
        repeat (8) @(negedge clk);
        d = dataWire;
        oe = devOe;
        readStrobeN = 1'b1;
        chipSelN = 1'b1;
        repeat (6) @(negedge clk);
    endtask
endmodule
`default_nettype wire

/* tb/test_rcsir_top.sv */
// Self-checking bench for the location-15 register block.
// Assumes the processor model drives the bus; events come from here.
`timescale 1ns/1ps
`default_nettype none

module test_rcsir_top;
    logic       clk;
    logic       rst;
    logic       settingPulse;
    logic       pmRollover;
    logic       yearRollover;
    wire        chipSelN;
    wire        readStrobeN;
    wire        writeStrobeN;
    wire  [3:0] addrPin;
    wire  [3:0] dataWire;
    wire  [3:0] devOut;
    wire  [3:0] devOe;
    wire        irqPinOut;
    wire        irqPinOe;
    wire        pmIndicator;
    wire        hourModeBit;
    wire  [1:0] leapCount;
    wire        febDay29Allowed;
    wire        intSelect;
    logic [3:0] rd;
    logic [3:0] oe;
    logic [9:0] tickTab [1:7];
    int         errCount;
    int         testsRun;

    rcsir_top u_rcsir_top (.clk(clk), .rst(rst), .chipSelN(chipSelN),
        .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
        .addrPin(addrPin), .dataBitZeroIn(dataWire[0]),
        .dataBitZeroOut(devOut[0]), .dataBitZeroOe(devOe[0]),
        .dataBitOneIn(dataWire[1]), .dataBitOneOut(devOut[1]),
        .dataBitOneOe(devOe[1]), .dataBitTwoIn(dataWire[2]),
        .dataBitTwoOut(devOut[2]), .dataBitTwoOe(devOe[2]),
        .dataBitThreeIn(dataWire[3]), .dataBitThreeOut(devOut[3]),
        .dataBitThreeOe(devOe[3]), .irqPinOut(irqPinOut),
        .irqPinOe(irqPinOe), .settingPulse(settingPulse),
        .pmRollover(pmRollover), .yearRollover(yearRollover),
        .pmIndicator(pmIndicator), .hourModeBit(hourModeBit),
        .leapCount(leapCount), .febDay29Allowed(febDay29Allowed),
        .intSelect(intSelect));
    rcsir_cpu_model u_rcsir_cpu_model (.clk(clk), .chipSelN(chipSelN),
        .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
        .addrPin(addrPin), .devOut(devOut), .devOe(devOe),
        .dataWire(dataWire));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        testsRun = testsRun + 1;
        if (got !== exp) begin
            errCount = errCount + 1;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [3:0] e);
        u_rcsir_cpu_model.busRead(a, rd, oe);
        check(rd, e);
        check(oe, 4'hF);
    endtask
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        u_rcsir_cpu_model.busWrite(a, d);
    endtask
    task automatic event1(input int which);
        @(negedge clk);
        settingPulse = (which == 0);
        pmRollover = (which == 1);
        yearRollover = (which == 2);
        @(negedge clk);
        {settingPulse, pmRollover, yearRollover} = 3'h0;
        repeat (4) @(negedge clk);
    endtask
    // Counts ticks until the interrupt pin pulls low
    task automatic waitIrq(input logic [9:0] n);
        logic [9:0] cnt;
        cnt = 10'h000;
        while (irqPinOe !== 1'b1 && cnt < n + 10'h002) begin
            event1(0);
            cnt = cnt + 10'h001;
        end
        testsRun = testsRun + 1;
        if (cnt !== n) begin
            errCount = errCount + 1;
            $display("mismatch at %0t got %h expected %h", $time, cnt, n);
            end_of_test();
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        check({intSelect, irqPinOe, 2'h0}, 4'h0);
        check({2'h0, febDay29Allowed, pmIndicator}, 4'h2);
        check({leapCount, hourModeBit, irqPinOut}, 4'h0);
        rdChk(4'hF, 4'h0);
    endtask
    task automatic t_csr;
        wr(4'h0, 4'h1);
        wr(4'hF, 4'hC);
        wr(4'hF, 4'hE);
        rdChk(4'hF, 4'hE);
        check({leapCount, febDay29Allowed, pmIndicator}, 4'hD);
        event1(2);
        check({leapCount, febDay29Allowed, pmIndicator}, 4'h3);
        event1(1);
        check({2'h0, pmIndicator, hourModeBit}, 4'h0);
        rdChk(4'hF, 4'h0);
    endtask
    task automatic t_sel;
        wr(4'h0, 4'h3);
        wr(4'hF, 4'h9);
        rdChk(4'hF, 4'h9);
        event1(2);
        check({intSelect, 1'b0, leapCount}, 4'h9);
        wr(4'h5, 4'hF);
        wr(4'h0, 4'h1);
        rdChk(4'hF, 4'h4);
        u_rcsir_cpu_model.busRead(4'h5, rd, oe);
        check(oe, 4'h0);
    endtask
    task automatic t_single;
        for (int c = 1; c <= 7; c++) begin
            wr(4'h0, 4'h3);
            wr(4'hF, c[3:0]);
            wr(4'h0, 4'h2);
            waitIrq(tickTab[c]);
            rdChk(4'h0, 4'h1);
            check({3'h0, irqPinOe}, 4'h0);
            repeat (2) event1(0);
            check({3'h0, irqPinOe}, 4'h0);
        end
    endtask
    task automatic t_repeat;
        wr(4'h0, 4'h3);
        wr(4'hF, 4'hA);
        wr(4'h0, 4'h2);
        waitIrq(10'h005);
        rdChk(4'hF, 4'hA);
        check({3'h0, irqPinOe}, 4'h1);
        rdChk(4'h0, 4'h1);
        waitIrq(10'h005);
        wr(4'hF, 4'h0);
        check({3'h0, irqPinOe}, 4'h0);
        wr(4'hF, 4'h1);
        repeat (3) event1(0);
        check({3'h0, irqPinOe}, 4'h0);
    endtask
    initial begin
        tickTab = '{10'h001, 10'h005, 10'h00A, 10'h032, 10'h064, 10'h12C,
                    10'h258};
        errCount = 0;
        testsRun = 0;
        rst = 1'b1;
        {settingPulse, pmRollover, yearRollover} = 3'h0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        t_reset();
        t_csr();
        t_sel();
        t_single();
        t_repeat();
        end_of_test();
    end
endmodule
`default_nettype wire
